// >>> inc/swc_pkg.sv
// Shared constants and carrier types for the sleep and wake-up controller
`default_nettype none
package swc_pkg;
  // =====================================================
  // Widths, wake sources, vector and PC step
  localparam int unsigned IRQ_W = 12;
  localparam int unsigned PORT_W = 24;
  localparam int unsigned PC_W = 13;
  localparam logic [IRQ_W-1:0] WAKE_CAPABLE = 12'h3ff;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  // =====================================================
  // Register map and fields
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] IRQ_EN_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] PEND_OFS = 8'h0c;
  localparam int unsigned CTRL_GIE_BIT = 0;
  localparam int unsigned CTRL_WDT_EN_BIT = 1;
  localparam int unsigned ST_SLEEP_BIT = 0;
  localparam int unsigned ST_WAKE_REQ_BIT = 1;
  localparam int unsigned ST_PD_BIT = 3;
  localparam int unsigned ST_TO_BIT = 4;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 12'h000;
  localparam logic PD_RESET = 1'b1;
  localparam logic TO_RESET = 1'b1;
  // =====================================================
  // Watchdog period
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned WDT_PERIOD_US = 1000;
  localparam int unsigned WDT_CYCLES = WDT_PERIOD_US * CLK_MHZ;
  // =====================================================
  // Carrier types
  typedef enum logic {SWC_RUN, SWC_SLEEP} swc_state_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } swc_apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } swc_apb_rsp_type;
endpackage
`default_nettype wire

// >>> design/swc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module swc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      level_q <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level_o = level_q;
endmodule // swc_sync
`default_nettype wire

// >>> design/swc_watchdog.sv
// Free-running watchdog counter with clear and time-out pulse
`timescale 1ns/1ns
`default_nettype none
module swc_watchdog #(
  parameter int unsigned LIMIT = 100000
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire logic clear_i,
  output logic timeout_o
);
  logic [31:0] count_q;
  logic timeout_q;
  logic at_limit;

  assign at_limit = (count_q == 32'(LIMIT - 1));

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || clear_i || !enable_i || at_limit) begin
      count_q <= 32'h0;
    end else begin
      count_q <= count_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= enable_i && !clear_i && at_limit;
    end
  end

  assign timeout_o = timeout_q;
endmodule // swc_watchdog
`default_nettype wire

// >>> design/swc_ctrl.sv
// Sleep and wake-up controller: halt handling, wake decision, status flags
// Operation
// - Halt instruction enters power-down state.
// - Entry clears watchdog, flags, stops oscillator (code clears the power-down flag but sets the time-out flag).
// - Port pins hold pre-halt drive state.
// - Wake on reset pin, watchdog, interrupt.
// - Reset pin resets; others resume execution.
// - Power-down flag set at power-up, cleared by halt.
// - Watchdog wake clears time-out flag.
// - Only listed peripherals may wake.
// - Other peripherals cannot interrupt while asleep.
// - Halt prefetches instruction at PC plus one.
// - Wake needs individual enable; global ignored.
// - Global clear: continue after halt.
// - Global set: next instruction, then vector.
// - Pending enabled interrupt makes halt a no-op.
// - Interrupt during halt: full halt, immediate wake.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module swc_ctrl
  import swc_pkg::*;
#(
  parameter int unsigned WDT_LIMIT = swc_pkg::WDT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire swc_pkg::swc_apb_req_type apb_req_i,
  output swc_pkg::swc_apb_rsp_type apb_rsp_o,
  input wire logic halt_instr_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic [swc_pkg::PC_W-1:0] pc_i,
  input wire logic [swc_pkg::IRQ_W-1:0] irq_flags_i,
  input wire logic master_clear_pin_n_i,
  input wire logic [swc_pkg::PORT_W-1:0] port_out_i,
  input wire logic [swc_pkg::PORT_W-1:0] port_oe_i,
  output logic [swc_pkg::PORT_W-1:0] port_pin_o,
  output logic [swc_pkg::PORT_W-1:0] port_pin_oe_o,
  output logic osc_drive_en_o,
  output logic sleeping_o,
  output logic core_reset_o,
  output logic resume_o,
  output logic vector_branch_o,
  output logic [swc_pkg::PC_W-1:0] vector_addr_o,
  output logic [swc_pkg::PC_W-1:0] prefetch_addr_o,
  output logic power_down_flag_o,
  output logic timeout_flag_o
);
  import swc_pkg::*;

  // =====================================================
  // Declarations
  swc_state_type state_q;
  logic global_irq_enable_q;
  logic wdt_en_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic power_down_flag_q;
  logic timeout_flag_q;
  logic core_reset_q;
  logic resume_q;
  logic vector_branch_q;
  logic [PC_W-1:0] prefetch_addr_q;
  logic [PORT_W-1:0] port_pin_q;
  logic [PORT_W-1:0] port_pin_oe_q;
  logic [31:0] prdata_q;
  logic master_clear_pin_n;
  logic master_clear_pin_low;
  logic wdt_timeout;
  logic wdt_clear;
  logic wake_req;
  logic halt_nop;
  logic halt_enter;
  logic sleep_irq_wake;
  logic sleep_wdt_wake;
  logic wdt_run_reset;
  logic apb_setup;
  logic apb_write;
  logic addr_ok;

  // =====================================================
  // Pin synchroniser and watchdog
  swc_sync #(
    .RESET_VAL(1'b1)
  ) u_master_clear_pin_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .async_i(master_clear_pin_n_i),
    .level_o(master_clear_pin_n)
  );

  swc_watchdog #(
    .LIMIT(WDT_LIMIT)
  ) u_watchdog (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .enable_i(wdt_en_q),
    .clear_i(wdt_clear),
    .timeout_o(wdt_timeout)
  );

  // =====================================================
  // Wake decision
  assign master_clear_pin_low = !master_clear_pin_n;
  // Global enable plays no part in the request
  assign wake_req = |(irq_flags_i & irq_en_q & WAKE_CAPABLE);
  assign halt_nop = (state_q == SWC_RUN) && halt_instr_i && wake_req && !master_clear_pin_low;
  assign halt_enter = (state_q == SWC_RUN) && halt_instr_i && !wake_req && !master_clear_pin_low;
  assign sleep_wdt_wake = (state_q == SWC_SLEEP) && !master_clear_pin_low && wdt_timeout;
  assign sleep_irq_wake = (state_q == SWC_SLEEP) && !master_clear_pin_low && !wdt_timeout && wake_req;
  assign wdt_run_reset = (state_q == SWC_RUN) && !master_clear_pin_low && !halt_instr_i && wdt_timeout;
  assign wdt_clear = halt_enter || watchdog_clear_instr_i;

  // =====================================================
  // Power state
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_q <= SWC_RUN;
    end else begin
      unique case (state_q)
        SWC_RUN: begin
          if (halt_enter) begin
            state_q <= SWC_SLEEP;
          end
        end
        SWC_SLEEP: begin
          if (master_clear_pin_low || wdt_timeout || wake_req) begin
            state_q <= SWC_RUN;
          end
        end
      endcase
    end
  end

  // Outputs that tell the core how to leave power-down or to reset while running
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      core_reset_q <= 1'b0;
      resume_q <= 1'b0;
      vector_branch_q <= 1'b0;
    end else begin
      core_reset_q <= master_clear_pin_low || wdt_run_reset;
      resume_q <= sleep_wdt_wake || sleep_irq_wake;
      vector_branch_q <= sleep_irq_wake && global_irq_enable_q;
    end
  end

  // Address of the instruction fetched while the halt executes
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      prefetch_addr_q <= '0;
    end else if ((state_q == SWC_RUN) && halt_instr_i) begin
      prefetch_addr_q <= pc_i + PC_STEP;
    end
  end

  // Port drive follows the core until halted, then freezes
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      port_pin_q <= '0;
      port_pin_oe_q <= '0;
    end else if (!(state_q == SWC_SLEEP && !master_clear_pin_low && !wdt_timeout && !wake_req)
                 && !halt_enter) begin
      port_pin_q <= port_out_i;
      port_pin_oe_q <= port_oe_i;
    end
  end

  // =====================================================
  // Status flags
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      power_down_flag_q <= PD_RESET;
      timeout_flag_q <= TO_RESET;
    end else if (halt_enter) begin
      power_down_flag_q <= 1'b0;
      timeout_flag_q <= 1'b1;
    end else if (sleep_wdt_wake) begin
      timeout_flag_q <= 1'b0;
    end else if (wdt_run_reset) begin
      power_down_flag_q <= 1'b1;
      timeout_flag_q <= 1'b0;
    end else if (watchdog_clear_instr_i && state_q == SWC_RUN) begin
      power_down_flag_q <= 1'b1;
      timeout_flag_q <= 1'b1;
    end
  end

  // =====================================================
  // APB slave
  assign apb_setup = apb_req_i.psel && !apb_req_i.penable;
  assign apb_write = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  assign addr_ok = (apb_req_i.paddr == CTRL_OFS) || (apb_req_i.paddr == IRQ_EN_OFS)
                   || (apb_req_i.paddr == STATUS_OFS) || (apb_req_i.paddr == PEND_OFS);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      global_irq_enable_q <= CTRL_RESET[CTRL_GIE_BIT];
      wdt_en_q <= CTRL_RESET[CTRL_WDT_EN_BIT];
    end else if (apb_write && apb_req_i.paddr == CTRL_OFS) begin
      global_irq_enable_q <= apb_req_i.pwdata[CTRL_GIE_BIT];
      wdt_en_q <= apb_req_i.pwdata[CTRL_WDT_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      irq_en_q <= IRQ_EN_RESET;
    end else if (apb_write && apb_req_i.paddr == IRQ_EN_OFS) begin
      irq_en_q <= apb_req_i.pwdata[IRQ_W-1:0];
    end
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      prdata_q <= 32'h0;
    end else if (apb_setup) begin
      prdata_q <= 32'h0;
      if (apb_req_i.paddr == CTRL_OFS) begin
        prdata_q[CTRL_GIE_BIT] <= global_irq_enable_q;
        prdata_q[CTRL_WDT_EN_BIT] <= wdt_en_q;
      end else if (apb_req_i.paddr == IRQ_EN_OFS) begin
        prdata_q[IRQ_W-1:0] <= irq_en_q;
      end else if (apb_req_i.paddr == STATUS_OFS) begin
        prdata_q[ST_SLEEP_BIT] <= (state_q == SWC_SLEEP);
        prdata_q[ST_WAKE_REQ_BIT] <= wake_req;
        prdata_q[ST_PD_BIT] <= power_down_flag_q;
        prdata_q[ST_TO_BIT] <= timeout_flag_q;
      end else if (apb_req_i.paddr == PEND_OFS) begin
        prdata_q[IRQ_W-1:0] <= irq_flags_i & irq_en_q;
      end
    end
  end

  assign apb_rsp_o.pready = 1'b1;
  assign apb_rsp_o.pslverr = apb_req_i.psel && apb_req_i.penable && !addr_ok;
  assign apb_rsp_o.prdata = prdata_q;

  // =====================================================
  // Outputs
  assign osc_drive_en_o = (state_q == SWC_RUN);
  assign sleeping_o = (state_q == SWC_SLEEP);
  assign core_reset_o = core_reset_q;
  assign resume_o = resume_q;
  assign vector_branch_o = vector_branch_q;
  assign vector_addr_o = IRQ_VECTOR;
  assign prefetch_addr_o = prefetch_addr_q;
  assign port_pin_o = port_pin_q;
  assign port_pin_oe_o = port_pin_oe_q;
  assign power_down_flag_o = power_down_flag_q;
  assign timeout_flag_o = timeout_flag_q;

  // =====================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_halt_entry;
    halt_enter |=> sleeping_o && !power_down_flag_o && timeout_flag_o && !osc_drive_en_o;
  endproperty
  a_halt_entry: assert property (p_halt_entry) else $error("halt did not enter sleep");

  property p_port_hold;
    sleeping_o && $past(sleeping_o) |-> $stable(port_pin_o) && $stable(port_pin_oe_o);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port changed in sleep");

  property p_master_clear_pin_reset;
    sleeping_o && master_clear_pin_low |=> core_reset_o && !sleeping_o && !resume_o;
  endproperty
  a_master_clear_pin_reset: assert property (p_master_clear_pin_reset) else $error("reset pin missed in sleep");

  property p_wdt_wake;
    sleep_wdt_wake |=> resume_o && !timeout_flag_o && !power_down_flag_o && !core_reset_o;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  property p_prefetch;
    halt_enter |=> prefetch_addr_o == $past(pc_i) + PC_STEP;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetch address wrong");

  property p_branch;
    resume_o |-> vector_branch_o == ($past(global_irq_enable_q) && !$past(wdt_timeout));
  endproperty
  a_branch: assert property (p_branch) else $error("vector branch wrong");

  property p_nop_halt;
    halt_nop && !watchdog_clear_instr_i && !wdt_timeout
      |=> !sleeping_o && $stable(power_down_flag_o) && $stable(timeout_flag_o);
  endproperty
  a_nop_halt: assert property (p_nop_halt) else $error("halt not a no-op");

  property p_irq_wake;
    sleeping_o && wake_req && !master_clear_pin_low |=> !sleeping_o && resume_o ##1 !resume_o;
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("interrupt wake wrong");

  property p_masked_stay;
    sleeping_o && !master_clear_pin_low && !wdt_timeout && ((irq_flags_i & irq_en_q & WAKE_CAPABLE) == '0)
      |=> sleeping_o;
  endproperty
  a_masked_stay: assert property (p_masked_stay) else $error("woke without cause");

  property p_pd_cleared_once;
    $fell(power_down_flag_o) |-> $past(halt_enter);
  endproperty
  a_pd_cleared_once: assert property (p_pd_cleared_once) else $error("flag cleared no halt");

  property p_run_timeout;
    wdt_run_reset |=> core_reset_o && !timeout_flag_o && power_down_flag_o && !sleeping_o;
  endproperty
  a_run_timeout: assert property (p_run_timeout) else $error("run time-out wrong");

  property p_resume_pulse;
    resume_o |=> !resume_o;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse) else $error("resume not a pulse");

  property p_wdt_clear_flags;
    watchdog_clear_instr_i && !sleeping_o && !halt_instr_i && !wdt_timeout
      |=> power_down_flag_o && timeout_flag_o;
  endproperty
  a_wdt_clear_flags: assert property (p_wdt_clear_flags) else $error("clear left flags");

  property p_wake_cause;
    $fell(sleeping_o) |-> $past(master_clear_pin_low || wdt_timeout || wake_req);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("left sleep without cause");

  property p_irq_wake_flags;
    sleep_irq_wake |=> !power_down_flag_o && timeout_flag_o;
  endproperty
  a_irq_wake_flags: assert property (p_irq_wake_flags) else $error("irq wake flags wrong");

  property p_master_clear_pin_run;
    !sleeping_o && master_clear_pin_low |=> core_reset_o && !sleeping_o;
  endproperty
  a_master_clear_pin_run: assert property (p_master_clear_pin_run) else $error("reset pin missed in run");

  c_halt_nop: cover property (halt_nop);
  c_irq_branch: cover property (sleeping_o ##1 vector_branch_o);
  c_wdt_wake: cover property (sleep_wdt_wake ##1 resume_o);
  c_master_clear_pin_sleep: cover property (sleeping_o && master_clear_pin_low);
  c_run_timeout: cover property (wdt_run_reset);
endmodule // swc_ctrl
`default_nettype wire

// >>> testbench/swc_src_model.sv
// Model of the interrupt sources and the reset pin beside the controller
`timescale 1ns/1ns
`default_nettype none
module swc_src_model
  import swc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [swc_pkg::IRQ_W-1:0] raise_i,
  input wire logic [swc_pkg::IRQ_W-1:0] drop_i,
  input wire logic [3:0] lag_i,
  input wire logic pin_low_i,
  output logic [swc_pkg::IRQ_W-1:0] irq_flags_o,
  output logic master_clear_pin_n_o
);
  import swc_pkg::*;
  logic [IRQ_W-1:0] flags_q;
  logic [IRQ_W-1:0] pend_q;
  logic [3:0] cnt_q;
  logic pin_q;
  logic fire;
  assign fire = (pend_q != '0) && (cnt_q == 4'h0);
  // =====================================================
  // Flags are levels held until software drops them; lag_i gives a slow source
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      flags_q <= '0;
      pend_q <= '0;
      cnt_q <= 4'h0;
    end else begin
      flags_q <= (flags_q | ({IRQ_W{fire}} & pend_q)) & ~drop_i;
      if (raise_i != '0) begin
        pend_q <= raise_i;
        cnt_q <= lag_i;
      end else if (fire) begin
        pend_q <= '0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  // =====================================================
  // Pin is pulled up, so it rests high unless asked low
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= !pin_low_i;
    end
  end
  assign irq_flags_o = flags_q;
  assign master_clear_pin_n_o = pin_q;
endmodule // swc_src_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the sleep and wake-up controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import swc_pkg::*;
  int n_mismatch;
  int tests_run;
  logic ref_clk, resetn, halt, wd_clear, pin_low, pin_n, osc_en, sleeping;
  logic core_reset, resume, vbranch, power_down_flag, timeout_flag, err, r_w, v_w, c_w;
  logic [PC_W-1:0] pc, vaddr, prefetch;
  logic [IRQ_W-1:0] raise, drop, irq_flags;
  logic [3:0] lag;
  logic [PORT_W-1:0] port_out, port_oe, port_pin, port_pin_oe;
  logic [31:0] rd;
  swc_apb_req_type req;
  swc_apb_rsp_type rsp;
  swc_ctrl #(.WDT_LIMIT(20)) u_dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .apb_req_i(req),
    .apb_rsp_o(rsp), .halt_instr_i(halt), .watchdog_clear_instr_i(wd_clear), .pc_i(pc),
    .irq_flags_i(irq_flags), .master_clear_pin_n_i(pin_n), .port_out_i(port_out),
    .port_oe_i(port_oe), .port_pin_o(port_pin), .port_pin_oe_o(port_pin_oe),
    .osc_drive_en_o(osc_en), .sleeping_o(sleeping), .core_reset_o(core_reset),
    .resume_o(resume), .vector_branch_o(vbranch), .vector_addr_o(vaddr),
    .prefetch_addr_o(prefetch), .power_down_flag_o(power_down_flag),
    .timeout_flag_o(timeout_flag));
  swc_src_model u_src (.ref_clk_i(ref_clk), .resetn_i(resetn), .raise_i(raise),
    .drop_i(drop), .lag_i(lag), .pin_low_i(pin_low), .irq_flags_o(irq_flags),
    .master_clear_pin_n_o(pin_n));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // =====================================================
  // Shared tasks
  task test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
  endtask
  task halt_at(input logic [PC_W-1:0] p);
    @(posedge ref_clk);
    halt <= 1'b1;
    pc <= p;
    @(posedge ref_clk);
    halt <= 1'b0;
    #1;
  endtask
  task src(input logic [IRQ_W-1:0] r, input logic [IRQ_W-1:0] d, input logic [3:0] l);
    @(posedge ref_clk);
    raise <= r;
    drop <= d;
    lag <= l;
    @(posedge ref_clk);
    raise <= '0;
    drop <= '0;
  endtask
  task wait_wake(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #1;
      if (resume === 1'b1 || core_reset === 1'b1) break;
    end
    r_w = resume;
    v_w = vbranch;
    c_w = core_reset;
    if (i == n) begin
      n_mismatch++;
      test_done();
    end
  endtask
  // =====================================================
  // Scenarios
  task t_reset;
    `CHK("power down", 1'b1, power_down_flag)
    `CHK("timeout", 1'b1, timeout_flag)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK("status", 32'h18, rd)
    apb(1'b1, IRQ_EN_OFS, 32'habc);
    apb(1'b0, IRQ_EN_OFS, 32'h0);
    `CHK("irq enable", 32'habc, rd)
    apb(1'b1, 8'h10, 32'hffffffff);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
  endtask
  task t_wake;
    int b;
    for (b = 0; b < 10; b++) begin
      apb(1'b1, CTRL_OFS, {31'h0, b[0]});
      apb(1'b1, IRQ_EN_OFS, 32'h1 << b);
      @(posedge ref_clk);
      port_out <= 24'h5a5a5a ^ b[23:0];
      port_oe <= 24'hff00ff;
      halt_at(13'h0123 + b[12:0]);
      `CHK("sleeping", 1'b1, sleeping)
      `CHK("osc", 1'b0, osc_en)
      `CHK("power down", 1'b0, power_down_flag)
      `CHK("timeout", 1'b1, timeout_flag)
      `CHK("prefetch", 13'h0124 + b[12:0], prefetch)
      @(posedge ref_clk);
      port_out <= '1;
      port_oe <= '0;
      src(12'h1 << b, 12'h0, b[3:0]);
      `CHK("pins", 24'h5a5a5a ^ b[23:0], port_pin)
      `CHK("pin enables", 24'hff00ff, port_pin_oe)
      wait_wake(40);
      `CHK("resume", 1'b1, r_w)
      `CHK("vector branch", b[0], v_w)
      `CHK("vector", 13'h0004, vaddr)
      `CHK("awake", 1'b0, sleeping)
      src(12'h0, 12'hfff, 4'h0);
    end
  endtask
  task t_masked;
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b1, IRQ_EN_OFS, 32'hc04);
    halt_at(13'h0200);
    src(12'hc0b, 12'h0, 4'h0);
    repeat (10) begin
      @(posedge ref_clk);
      #1;
      `CHK("stays asleep", 1'b1, sleeping)
    end
    src(12'h004, 12'h0, 4'h0);
    wait_wake(20);
    `CHK("wake", 1'b1, r_w)
    src(12'h0, 12'hfff, 4'h0);
  endtask
  task t_noop;
    @(posedge ref_clk);
    wd_clear <= 1'b1;
    @(posedge ref_clk);
    wd_clear <= 1'b0;
    apb(1'b1, IRQ_EN_OFS, 32'h4);
    src(12'h004, 12'h0, 4'h0);
    @(posedge ref_clk);
    halt_at(13'h0300);
    `CHK("no-op sleeping", 1'b0, sleeping)
    `CHK("no-op power down", 1'b1, power_down_flag)
    `CHK("no-op timeout", 1'b1, timeout_flag)
    `CHK("no-op prefetch", 13'h0301, prefetch)
    src(12'h0, 12'hfff, 4'h0);
  endtask
  task t_watchdog;
    apb(1'b1, IRQ_EN_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h2);
    halt_at(13'h0400);
    wait_wake(60);
    `CHK("watchdog wake", 1'b1, r_w)
    `CHK("watchdog no reset", 1'b0, c_w)
    `CHK("timeout", 1'b0, timeout_flag)
    `CHK("power down", 1'b0, power_down_flag)
    // Left running, the watchdog times out again while awake
    wait_wake(60);
    `CHK("run timeout reset", 1'b1, c_w)
    `CHK("run timeout no resume", 1'b0, r_w)
    `CHK("run timeout flag", 1'b0, timeout_flag)
    `CHK("run timeout power down", 1'b1, power_down_flag)
    apb(1'b1, CTRL_OFS, 32'h0);
  endtask
  task t_pin_reset;
    halt_at(13'h0500);
    @(posedge ref_clk);
    pin_low <= 1'b1;
    wait_wake(20);
    `CHK("pin reset", 1'b1, c_w)
    `CHK("pin no resume", 1'b0, r_w)
    `CHK("pin awake", 1'b0, sleeping)
    `CHK("pin timeout", 1'b1, timeout_flag)
    @(posedge ref_clk);
    pin_low <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    `CHK("reset released", 1'b0, core_reset)
  endtask
  task t_rerun;
    halt_at(13'h0600);
    `CHK("asleep before reset", 1'b1, sleeping)
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK("rerun power down", 1'b1, power_down_flag)
    `CHK("rerun timeout", 1'b1, timeout_flag)
    `CHK("rerun awake", 1'b0, sleeping)
    `CHK("rerun osc", 1'b1, osc_en)
  endtask
  // =====================================================
  // Main sequence
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    resetn = 1'b0;
    halt = 1'b0;
    wd_clear = 1'b0;
    pin_low = 1'b0;
    pc = '0;
    raise = '0;
    drop = '0;
    lag = 4'h0;
    port_out = '0;
    port_oe = '0;
    req = '0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_wake();
    t_masked();
    t_noop();
    t_watchdog();
    t_pin_reset();
    t_rerun();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
